// file: sttr_pkg.sv
// package: register indices, field layouts, reset values and timing for the secondary register slice
// Contract
// R1: turn-on delay bits 15:8 count secondary oscillator cycles of intermediate plateau.
// R2: turn-on delay zero disables two-level turn-on; gate switches directly.
// R3: host programs turn-on delay at least 0x0A when two-level turn-on used.
// R4: conversion result bits 15:8 overwritten on every completed conversion.
// R5: over-limit status bit 6 reads 1 while overvoltage violation is detected.
// R6: under-limit status bit 5 reads 1 while undervoltage violation is detected.
// R7: result valid bit 4 set on every result update and stays set.
// R8: boundary register writes accepted only while second config enable is set.
// R9: host puts upper limit in bits 15:10, lower limit in bits 9:4.
// R10: supervision cycle count written by hardware into read-only bits 15:8.
// R11: bit 1 of every register shows whether previous message was discarded.
// R12: bit 0 of every register carries odd parity over the returned word.
// R13: reserved bits read zero and ignore writes.
package sttr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // register selectors (no printed offsets; local indices)
  localparam logic [1:0] SEL_TWO_LEVEL_TURN_ON = 2'h0;
  localparam logic [1:0] SEL_ADC  = 2'h1;
  localparam logic [1:0] SEL_BND  = 2'h2;
  localparam logic [1:0] SEL_SCS  = 2'h3;
  // field positions
  localparam int unsigned DATA_MSB  = 15;
  localparam int unsigned DATA_LSB  = 8;
  localparam int unsigned OVS_BIT   = 6;
  localparam int unsigned UVS_BIT   = 5;
  localparam int unsigned VAL_BIT   = 4;
  localparam int unsigned UPB_MSB   = 15;
  localparam int unsigned UPB_LSB   = 10;
  localparam int unsigned LOB_MSB   = 9;
  localparam int unsigned LOB_LSB   = 4;
  localparam int unsigned LMI_BIT   = 1;
  localparam int unsigned PAR_BIT   = 0;
  // reset values, minimum turn-on delay and turn-on states
  localparam logic [7:0]  TWO_LEVEL_TURN_ON_RST  = 8'h00;
  localparam logic [5:0]  UPB_RST   = 6'h3F;
  localparam logic [5:0]  LOB_RST   = 6'h00;
  localparam logic [7:0]  RES_RST   = 8'h00;
  localparam logic [7:0]  SCS_RST   = 8'h00;
  localparam logic [7:0]  TWO_LEVEL_TURN_ON_MIN  = 8'h0A;
  typedef enum logic [1:0] {
    STTR_IDLE    = 2'b00,
    STTR_PLATEAU = 2'b01,
    STTR_FULL    = 2'b10
  } sttr_ton_e;
endpackage

// file: sttr_cfg_if.sv
// interface: configuration carried from register slice to its helper modules
`timescale 1ns/1ps
interface sttr_cfg_if;
  logic [7:0] ton_delay;
  logic [5:0] upper_boundary;
  logic [5:0] lower_boundary;
  logic [7:0] conversion_result;
  modport regs (output ton_delay, output upper_boundary, output lower_boundary,
                output conversion_result);
  modport ton  (input ton_delay);
  modport lim  (input upper_boundary, input lower_boundary, input conversion_result);
endinterface

// file: sttr_ton_seq.sv
// module: two-level turn-on sequencer counting oscillator cycles
`timescale 1ns/1ps
module sttr_ton_seq
  import sttr_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  nrst,
  input  wire logic  osc_tick,
  input  wire logic  gate_on_req,
  sttr_cfg_if.ton    cfg,
  output logic       gate_plateau,
  output logic       gate_full
);
  sttr_ton_e  state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;

  // next state: plateau only when a nonzero delay is loaded
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      STTR_IDLE: begin
        if (gate_on_req) begin
          if (cfg.ton_delay == 8'h00) begin
            state_next = STTR_FULL; // R2
          end else begin
            state_next = STTR_PLATEAU;
            cnt_next   = cfg.ton_delay; // R1
          end
        end
      end
      STTR_PLATEAU: begin
        if (!gate_on_req) begin
          state_next = STTR_IDLE;
        end else if (osc_tick) begin
          if (cnt_reg == 8'h01) begin
            state_next = STTR_FULL; // R1
          end
          cnt_next = cnt_reg - 8'h01;
        end
      end
      STTR_FULL: begin
        if (!gate_on_req) begin
          state_next = STTR_IDLE;
        end
      end
      default: state_next = STTR_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= STTR_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign gate_plateau = (state_reg == STTR_PLATEAU);
  assign gate_full    = (state_reg == STTR_FULL);
endmodule

// file: sttr_limit_chk.sv
// module: compares the conversion result against the boundaries
`timescale 1ns/1ps
module sttr_limit_chk
  import sttr_pkg::*;
(
  sttr_cfg_if.lim cfg,
  output logic    over_limit,
  output logic    under_limit
);
  // boundaries are six bits; compare against the top six bits of the result
  assign over_limit  = cfg.conversion_result[7:2] > cfg.upper_boundary;
  assign under_limit = cfg.conversion_result[7:2] < cfg.lower_boundary;
endmodule

// file: sttr_regs.sv
// module: secondary turn-on, result, boundary and supervision registers
`timescale 1ns/1ps
module sttr_regs
  import sttr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [1:0]  reg_sel,
  input  wire logic [15:0] wr_data,
  input  wire logic        msg_done,
  input  wire logic        msg_invalid,
  input  wire logic        second_config_enable,
  input  wire logic        conv_done,
  input  wire logic [7:0]  conv_data,
  input  wire logic        supv_done,
  input  wire logic [7:0]  supv_count,
  input  wire logic        osc_tick,
  input  wire logic        gate_on_req,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  output logic             gate_plateau,
  output logic             gate_full,
  output logic             over_limit_status,
  output logic             under_limit_status
);
  sttr_cfg_if cfg_bus ();

  logic [7:0]  ton_reg, ton_next;
  logic [7:0]  res_reg, res_next;
  logic        val_reg, val_next;
  logic [5:0]  upb_reg, upb_next;
  logic [5:0]  lob_reg, lob_next;
  logic [7:0]  scs_reg, scs_next;
  logic        lmi_reg, lmi_next;
  logic [15:0] rdd_reg, rdd_next;
  logic        rdv_reg, rdv_next;
  logic        ovs_reg, ovs_next;
  logic        uvs_reg, uvs_next;
  logic        plat_reg, full_reg;
  logic        ovr_c, und_c, plat_c, full_c;
  logic [15:0] word_c;

  assign cfg_bus.ton_delay         = ton_reg;
  assign cfg_bus.upper_boundary    = upb_reg;
  assign cfg_bus.lower_boundary    = lob_reg;
  assign cfg_bus.conversion_result = res_reg;

  sttr_ton_seq u_ton (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .osc_tick     (osc_tick),
    .gate_on_req  (gate_on_req),
    .cfg          (cfg_bus.ton),
    .gate_plateau (plat_c),
    .gate_full    (full_c)
  );

  sttr_limit_chk u_lim (
    .cfg         (cfg_bus.lim),
    .over_limit  (ovr_c),
    .under_limit (und_c)
  );

  // next values of stored fields and the read word
  always_comb begin
    ton_next = ton_reg;
    res_next = res_reg;
    val_next = val_reg;
    upb_next = upb_reg;
    lob_next = lob_reg;
    scs_next = scs_reg;
    lmi_next = lmi_reg;
    word_c   = 16'h0000; // R13
    if (wr_en && reg_sel == SEL_TWO_LEVEL_TURN_ON) begin
      ton_next = wr_data[DATA_MSB:DATA_LSB]; // R1
    end
    // boundary writes only land while the second configuration enable is up
    if (wr_en && reg_sel == SEL_BND && second_config_enable) begin // R8
      upb_next = wr_data[UPB_MSB:UPB_LSB];
      lob_next = wr_data[LOB_MSB:LOB_LSB];
    end
    if (conv_done) begin
      res_next = conv_data; // R4
      val_next = 1'b1;      // R7
    end
    if (supv_done) begin
      scs_next = supv_count; // R10
    end
    if (msg_done) begin
      lmi_next = msg_invalid; // R11
    end
    unique case (reg_sel)
      SEL_TWO_LEVEL_TURN_ON: word_c[DATA_MSB:DATA_LSB] = ton_reg;
      SEL_ADC: begin
        word_c[DATA_MSB:DATA_LSB] = res_reg;
        word_c[OVS_BIT]           = ovs_reg; // R5
        word_c[UVS_BIT]           = uvs_reg; // R6
        word_c[VAL_BIT]           = val_reg; // R7
      end
      SEL_BND: begin
        word_c[UPB_MSB:UPB_LSB] = upb_reg;
        word_c[LOB_MSB:LOB_LSB] = lob_reg;
      end
      SEL_SCS: word_c[DATA_MSB:DATA_LSB] = scs_reg;
    endcase
    word_c[LMI_BIT] = lmi_reg; // R11
    // odd parity: total ones including bit 0 is odd
    word_c[PAR_BIT] = ~(^word_c[15:1]); // R12
    rdd_next = rd_en ? word_c : rdd_reg;
    rdv_next = rd_en;
    ovs_next = ovr_c; // R5
    uvs_next = und_c; // R6
  end

  // register stage; outputs all come from flops
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ton_reg  <= TWO_LEVEL_TURN_ON_RST;
      res_reg  <= RES_RST;
      val_reg  <= 1'b0;
      upb_reg  <= UPB_RST;
      lob_reg  <= LOB_RST;
      scs_reg  <= SCS_RST;
      lmi_reg  <= 1'b0;
      rdd_reg  <= 16'h0000;
      rdv_reg  <= 1'b0;
      ovs_reg  <= 1'b0;
      uvs_reg  <= 1'b0;
      plat_reg <= 1'b0;
      full_reg <= 1'b0;
    end else begin
      ton_reg  <= ton_next;
      res_reg  <= res_next;
      val_reg  <= val_next;
      upb_reg  <= upb_next;
      lob_reg  <= lob_next;
      scs_reg  <= scs_next;
      lmi_reg  <= lmi_next;
      rdd_reg  <= rdd_next;
      rdv_reg  <= rdv_next;
      ovs_reg  <= ovs_next;
      uvs_reg  <= uvs_next;
      plat_reg <= plat_c;
      full_reg <= full_c;
    end
  end

  assign rd_data            = rdd_reg;
  assign rd_valid           = rdv_reg;
  assign over_limit_status  = ovs_reg;
  assign under_limit_status = uvs_reg;
  assign gate_plateau       = plat_reg;
  assign gate_full          = full_reg;
endmodule

// file: sttr_regs_chk.sv
// checker: port-level properties of the secondary register slice
`timescale 1ns/1ps
module sttr_regs_chk
  import sttr_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        rd_en,
  input wire logic [1:0]  reg_sel,
  input wire logic        msg_done,
  input wire logic        msg_invalid,
  input wire logic        conv_done,
  input wire logic [7:0]  conv_data,
  input wire logic        gate_on_req,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        gate_plateau,
  input wire logic        gate_full,
  input wire logic        over_limit_status,
  input wire logic        under_limit_status
);
  logic [8:0] conv_h;
  logic       bad_h;
  // last result and message fate, so reads are judged without replaying traffic
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      conv_h <= 9'h000;
      bad_h  <= 1'b0;
    end else begin
      if (conv_done) conv_h <= {1'b1, conv_data};
      if (msg_done) bad_h <= msg_invalid;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_parity_odd: assert property (rd_valid |-> ^rd_data)
    else $error("even parity");
  chk_reserved_low: assert property (rd_valid |-> rd_data[3:2] == 2'h0)
    else $error("reserved bits set");
  chk_delay_reserved: assert property (
    rd_valid && $past(reg_sel) == SEL_TWO_LEVEL_TURN_ON |-> rd_data[7:2] == 6'h00) else $error("delay rsvd");
  chk_last_fate: assert property (rd_en |=> rd_data[1] == $past(bad_h))
    else $error("wrong message fate");
  chk_result_load: assert property (
    rd_en && reg_sel == SEL_ADC |=> {rd_data[4], rd_data[15:8]} == $past(conv_h))
    else $error("stale result");
  chk_status_bits: assert property (rd_en && reg_sel == SEL_ADC |=>
    rd_data[7:5] == {1'b0, $past(over_limit_status), $past(under_limit_status)})
    else $error("status bits");
  chk_gate_excl: assert property (gate_plateau |-> !gate_full)
    else $error("plateau with full");
  chk_gate_release: assert property (
    !gate_on_req [*2] |=> !gate_plateau && !gate_full) else $error("gate not idle");
  cover property (gate_plateau ##1 gate_full);
  cover property (over_limit_status);
  cover property (rd_valid && rd_data[1]);
  cover property (under_limit_status);
endmodule
bind sttr_regs sttr_regs_chk u_chk (.*);

// file: sttr_host.sv
// host model: one spi message becomes a message-done pulse, plus a register strobe unless it is discarded
`timescale 1ns/1ps
module sttr_host (
  input  wire logic        core_clk,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  output logic             wr_en,
  output logic             rd_en,
  output logic [1:0]       reg_sel,
  output logic [15:0]      wr_data,
  output logic             msg_done,
  output logic             msg_invalid
);
  initial {wr_en, rd_en, reg_sel, wr_data, msg_done, msg_invalid} = '0;
  // a discarded message never reaches the registers, only its fate does
  task automatic msg(input logic w, input logic [1:0] s, input logic [15:0] d,
                     input logic bad, output logic [15:0] q);
    @(negedge core_clk);
    {wr_en, rd_en, msg_done, msg_invalid} = {w & ~bad, ~w & ~bad, 1'b1, bad};
    reg_sel = s;
    wr_data = d;
    @(negedge core_clk);
    q = rd_valid ? rd_data : 16'hXXXX;
    {wr_en, rd_en, msg_done, msg_invalid} = '0;
    wr_data = ~d; // released bus never keeps a stale word
  endtask
endmodule

// file: sttr_regs_tb.sv
// testbench: register access, limit check and turn-on sequencing
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module sttr_regs_tb;
  import sttr_pkg::*;
  logic        core_clk = 1'b0, nrst = 1'b0, second_config_enable = 1'b0;
  logic        conv_done = 1'b0, supv_done = 1'b0, osc_tick = 1'b0, gate_on_req = 1'b0;
  logic        wr_en, rd_en, msg_done, msg_invalid, rd_valid;
  logic        gate_plateau, gate_full, over_limit_status, under_limit_status;
  logic [1:0]  reg_sel;
  logic [7:0]  conv_data = 8'h00, supv_count = 8'h00;
  logic [15:0] wr_data, rd_data, q;
  logic [7:0]  cv [3] = '{8'hFF, 8'h10, 8'h40};
  logic [1:0]  ce [3] = '{2'b10, 2'b01, 2'b00};
  int          n_fail = 0, checked = 0;
  sttr_regs dut (.*);
  sttr_host host (.*);
  always #(CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;
  // expected word: bit 0 made odd over the whole word
  function automatic logic [15:0] pw(input logic [15:0] w);
    return {w[15:1], ~^w[15:1]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] d);
    host.msg(1'b1, s, d, 1'b0, q);
  endtask
  task automatic rd(input logic [1:0] s, input logic [15:0] e);
    host.msg(1'b0, s, 16'h0000, 1'b0, q);
    `CHK("rd_data", pw(e), q)
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    final_report();
  end
  initial begin
    cyc(12);
    nrst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), i == 2 ? 16'hFC00 : 16'h0000);
    end
    $display("test reset done");
    `CHK("delay_min", 1'b1, 8'h0C >= TWO_LEVEL_TURN_ON_MIN)
    wr(SEL_TWO_LEVEL_TURN_ON, 16'h0CFF);
    rd(SEL_TWO_LEVEL_TURN_ON, 16'h0C00);
    gate_on_req = 1'b1;
    cyc(2);
    osc_tick = 1'b1;
    cyc(11);
    osc_tick = 1'b0;
    cyc(2);
    `CHK("gate", 2'b10, {gate_plateau, gate_full})
    osc_tick = 1'b1;
    cyc(1);
    osc_tick = 1'b0;
    cyc(3);
    `CHK("gate", 2'b01, {gate_plateau, gate_full})
    gate_on_req = 1'b0;
    wr(SEL_TWO_LEVEL_TURN_ON, 16'h0000);
    gate_on_req = 1'b1;
    cyc(2);
    `CHK("gate", 2'b01, {gate_plateau, gate_full})
    gate_on_req = 1'b0;
    $display("test turn_on done");
    wr(SEL_BND, 16'h808F);
    rd(SEL_BND, 16'hFC00);
    second_config_enable = 1'b1;
    wr(SEL_BND, 16'h808F);
    rd(SEL_BND, 16'h8080);
    foreach (cv[i]) begin
      conv_data = cv[i];
      conv_done = 1'b1;
      cyc(1);
      conv_done = 1'b0;
      cyc(2);
      rd(SEL_ADC, {cv[i], 1'b0, ce[i], 5'h10});
    end
    wr(SEL_ADC, 16'h00F0);
    rd(SEL_ADC, 16'h4010);
    supv_count = 8'hA5;
    supv_done = 1'b1;
    cyc(1);
    supv_done = 1'b0;
    wr(SEL_SCS, 16'hFFFC);
    rd(SEL_SCS, 16'hA500);
    $display("test adc done");
    host.msg(1'b1, SEL_TWO_LEVEL_TURN_ON, 16'h3300, 1'b1, q);
    rd(SEL_TWO_LEVEL_TURN_ON, 16'h0002);
    rd(SEL_TWO_LEVEL_TURN_ON, 16'h0000);
    $display("test last_message done");
    final_report();
  end
endmodule
